// file: adc_serial_sample_shutdown_ctl.sv
`timescale 1ns/10ps
`include "adc_port_consts.svh"

// Behaviour
// - results are straight binary, zero code at 0 V, all ones one LSB below reference.
// - on shared wire, drive data low on fourth falling edge after start bit.
// - active only while select_shutdown_n low; full shutdown while it is high.
// - at conversion end power down bias and reference; keep shifting LSB-first or zeros.
// - power down after conversion even with select held low; only shifting stays clocked.
// - while select high, shift clock and serial input do not affect state.
// - sampling window opens while bit before output_order_bit shifts in.
// - falling edge after output_order_bit received enters hold and starts conversion.
// - data changes on falling shift-clock edges, captured on rising edges.
// - leading zeros ignored; first one is start; three config bits; rest ignored.
// - decode input_mode_bit and polarity into single-ended or differential routing.
// - output_order_bit one gives zeros after MSB-first; zero appends LSB-first result.
module adc_serial_sample_shutdown_ctl (
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  input  wire logic                    select_shutdown_n_in,
  input  wire logic                    shift_clk_in,
  input  wire logic                    data_in,
  input  wire logic                    comparator_in,
  output logic                         data_out,
  output logic                         data_oe_out,
  output logic                         sample_window_out,
  output logic                         hold_out,
  output logic                         powered_out,
  output logic                         ref_hiz_out,
  output logic [11:0]                  trial_code_out,
  output adc_port_pkg::mux_route_t     mux_route_out
);
  import adc_port_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic       cs_s1, cs_s2, sck_s1, sck_s2, sck_s3, din_s1, din_s2, cmp_s1, cmp_s2;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end else begin
      cs_s1  <= select_shutdown_n_in;
      cs_s2  <= cs_s1;
      sck_s1 <= shift_clk_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      din_s1 <= data_in;
      din_s2 <= din_s1;
      cmp_s1 <= comparator_in;
      cmp_s2 <= cmp_s1;
    end
  end

  wire active   = ~cs_s2;
  wire sck_rise = sck_s2 & ~sck_s3;
  wire sck_fall = ~sck_s2 & sck_s3;

  // ****************************************
  // sequencer state
  // ****************************************
  seq_t        seq;
  logic [1:0]  cfg_cnt;
  mux_cfg_t    cfg;
  logic [5:0]  fall_cnt;
  logic [11:0] result;
  logic        conv_done;

  wire [5:0]  nf         = (fall_cnt == `FALL_MAX) ? fall_cnt : fall_cnt + 6'h01;
  wire        run_fall   = sck_fall && (seq != seq_wait_start);
  wire        in_conv    = (nf >= `FALL_FIRST) && (nf <= `FALL_LAST);
  wire        in_lsb     = (nf > `FALL_LAST) && (nf <= `FALL_LSB_END) && !cfg.output_order_bit;
  wire [3:0]  conv_idx   = 4'(`FALL_LAST - nf);
  wire [3:0]  lsb_idx    = 4'(nf - `FALL_LAST);
  // straight binary: each kept comparator decision is the code bit itself
  wire [11:0] kept_code  = result | ({11'h000, cmp_s2} << conv_idx);
  wire [11:0] next_trial = kept_code | ((conv_idx != 4'h0) ?
                           (`TRIAL_ONE << (conv_idx - 4'h1)) : `CODE_ZERO);
  wire        start_seen = sck_rise && (seq == seq_wait_start) && din_s2;

  always_ff @(posedge clk_in) begin
    if (!rstn_in || !active) begin
      seq      <= seq_wait_start;
      cfg_cnt  <= 2'h0;
      cfg      <= '0;
      fall_cnt <= 6'h00;
      result   <= `CODE_ZERO;
    end else begin
      case (seq)
        seq_wait_start: if (start_seen) begin
          seq <= seq_config;
        end
        seq_config: if (sck_rise) begin
          cfg     <= {cfg.odd_sign_bit, cfg.output_order_bit, din_s2};
          cfg_cnt <= cfg_cnt + 2'h1;
          if (cfg_cnt == `CFG_BITS - 2'h1) begin
            seq <= seq_run;
          end
        end
        seq_run: ;
        default: seq <= seq_wait_start;
      endcase
      if (run_fall) begin
        fall_cnt <= nf;
        if (in_conv) begin
          result <= kept_code;
        end
      end
    end
  end

  // ****************************************
  // analog control and data pin
  // ****************************************
  wire next_done = conv_done || (run_fall && nf == `FALL_LAST);
  wire next_pwr  = active && !next_done;

  always_ff @(posedge clk_in) begin
    if (!rstn_in || !active) begin
      conv_done         <= 1'b0;
      data_out          <= 1'b0;
      data_oe_out       <= 1'b0;
      sample_window_out <= 1'b0;
      hold_out          <= 1'b0;
      powered_out       <= 1'b0;
      ref_hiz_out       <= 1'b1;
      trial_code_out    <= `TRIAL_FIRST;
    end else begin
      conv_done   <= next_done;
      powered_out <= next_pwr;
      ref_hiz_out <= !next_pwr;
      if (run_fall) begin
        if (nf == `FALL_SAMPLE) begin
          sample_window_out <= 1'b1;
        end
        if (nf == `FALL_HOLD) begin
          sample_window_out <= 1'b0;
          hold_out          <= 1'b1;
          data_oe_out       <= 1'b1;
          data_out          <= 1'b0;
        end else if (in_conv) begin
          data_out       <= cmp_s2;
          trial_code_out <= next_trial;
        end else if (in_lsb) begin
          data_out <= result[lsb_idx];
        end else begin
          data_out <= 1'b0;
        end
        if (nf == `FALL_LAST) begin
          hold_out <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // channel routing
  // ****************************************
  wire [1:0] plus_dec  = cfg.odd_sign_bit ? 2'h2 : 2'h1;
  wire [2:0] minus_dec = cfg.input_mode_bit ? 3'h4 : (cfg.odd_sign_bit ? 3'h1 : 3'h2);

  always_ff @(posedge clk_in) begin
    if (!rstn_in || !active || seq != seq_run) begin
      mux_route_out <= '0;
    end else begin
      mux_route_out <= '{plus_sel: plus_dec, minus_sel: minus_dec};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence hold_edge_s;
    run_fall && active && nf == `FALL_HOLD;
  endsequence
  sequence conv_end_s;
    run_fall && active && nf == `FALL_LAST;
  endsequence

  select_high_idle_a: assert property (cs_s2
    |=> !data_oe_out && !powered_out && seq == seq_wait_start)
    else $error("select high but port not idle");
  drive_on_hold_a: assert property (hold_edge_s
    |=> data_oe_out && !data_out && hold_out)
    else $error("data pin not driven low at fourth falling edge");
  no_early_drive_a: assert property (data_oe_out |-> fall_cnt >= `FALL_HOLD)
    else $error("data pin driven before fourth falling edge");
  window_open_a: assert property (run_fall && nf == `FALL_SAMPLE && active
    |=> sample_window_out)
    else $error("sampling window did not open");
  window_close_a: assert property (hold_edge_s
    |=> !sample_window_out ##0 $fell(sample_window_out))
    else $error("sampling window did not close at hold");
  power_down_a: assert property (conv_end_s ##1 active [*2]
    |-> !powered_out && ref_hiz_out)
    else $error("bias not powered down after conversion");
  stays_down_a: assert property (conv_done && active |=> !powered_out)
    else $error("power returned with select still low");
  start_ignore_a: assert property (seq == seq_wait_start && sck_rise
    && !din_s2 && active |=> seq == seq_wait_start)
    else $error("leading zero taken as start");
  zeros_tail_a: assert property (run_fall && nf > `FALL_LAST
    && cfg.output_order_bit && active |=> !data_out)
    else $error("nonzero data after MSB-first result");
  mux_route_a: assert property (seq == seq_run && active && cfg.input_mode_bit
    |=> mux_route_out.minus_sel == 3'h4)
    else $error("single-ended mode not referenced to ground");
  data_hold_a: assert property (active && !sck_fall |=> $stable(data_out))
    else $error("data pin changed away from a falling edge");
  trial_midscale_a: assert property (seq == seq_wait_start
    |-> trial_code_out == `TRIAL_FIRST)
    else $error("first trial code not mid-scale");
  power_up_a: assert property (active && seq == seq_wait_start |=> powered_out)
    else $error("bias not powered while selected");
  hold_span_a: assert property (hold_out && active && !(run_fall && nf == `FALL_LAST)
    |=> hold_out)
    else $error("hold released before conversion end");
endmodule

// file: adc_port_consts.svh
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH

// falling shift-clock edges counted from the start bit
`define FALL_SAMPLE   6'h02
`define FALL_HOLD     6'h04
`define FALL_FIRST    6'h05
`define FALL_LAST     6'h10
`define FALL_LSB_END  6'h1b
`define FALL_MAX      6'h3f
`define CFG_BITS      2'h3
`define CODE_ZERO     12'h000
`define TRIAL_FIRST   12'h800
`define TRIAL_ONE     12'h001

`endif

// file: adc_port_pkg.sv
package adc_port_pkg;
  typedef enum logic [1:0] {seq_wait_start, seq_config, seq_run} seq_t;

  typedef struct packed {
    logic input_mode_bit;
    logic odd_sign_bit;
    logic output_order_bit;
  } mux_cfg_t;

  typedef struct packed {
    logic [1:0] plus_sel;
    logic [2:0] minus_sel;
  } mux_route_t;
endpackage

// file: host_model.sv
`timescale 1ns/10ps
module host_model (
  input  wire logic clk_in,
  input  wire logic wire_in,
  output logic      select_n_out,
  output logic      sclk_out,
  output logic      drive_out,
  output logic      oe_out
);
  logic [35:0] rx = '0;
  initial begin
    select_n_out = 1'b1;
    sclk_out = 1'b0;
    drive_out = 1'b0;
    oe_out = 1'b0;
  end
  // 100 clk_in cycles a shift clock period, i.e. 200 kHz
  task automatic half_wait();
    repeat (50) @(negedge clk_in);
  endtask
  // two leading zeros, start bit, three config bits, then listen
  task automatic transfer(input logic [2:0] cfg, input int n);
    logic [5:0] tx;
    tx = {3'b001, cfg};
    select_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      sclk_out = 1'b0;
      oe_out = (i < 6);
      drive_out = (i < 6) ? tx[5-i] : 1'b0;
      half_wait();
      sclk_out = 1'b1;
      rx[i] = wire_in;
      half_wait();
    end
    sclk_out = 1'b0;
  endtask
  task automatic end_frame();
    half_wait();
    select_n_out = 1'b1;
    repeat (8) @(negedge clk_in);
  endtask
  // pin activity while deselected
  task automatic noise();
    oe_out = 1'b1;
    repeat (12) begin
      sclk_out = ~sclk_out;
      drive_out = ~drive_out;
      half_wait();
    end
    oe_out = 1'b0;
  endtask
endmodule

// file: test_adc_serial_sample_shutdown_ctl.sv
`timescale 1ns/10ps
module test_adc_serial_sample_shutdown_ctl;
  import adc_port_pkg::*;
  logic        clk_in = 0, rstn_in = 0, comparator_in = 0, flip = 0;
  logic [11:0] target = '0;
  logic [35:0] smp, hld, pwr, oe;
  int          idx = 0, bad_count = 0, check_count = 0;
  logic        select_n, sclk, hdrive, hoe, wire_lv;
  logic        data_out, data_oe_out, sample_window_out, hold_out, powered_out, ref_hiz_out;
  logic [11:0] trial_code_out;
  mux_route_t  mux_route_out;
  always #25 clk_in = ~clk_in;
  always @(negedge clk_in) begin
    flip <= ~flip;
    comparator_in <= (trial_code_out <= target);
  end
  // a released wire shows a changing pattern, never a stale level
  assign wire_lv = data_oe_out ? data_out : (hoe ? hdrive : flip);
  always @(posedge sclk) begin
    smp[idx] = sample_window_out;
    hld[idx] = hold_out;
    pwr[idx] = powered_out;
    oe[idx] = data_oe_out;
    idx++;
  end
  adc_serial_sample_shutdown_ctl adc_serial_sample_shutdown_ctl_inst (.clk_in(clk_in),
    .rstn_in(rstn_in), .select_shutdown_n_in(select_n), .shift_clk_in(sclk), .data_in(wire_lv),
    .comparator_in(comparator_in), .data_out(data_out), .data_oe_out(data_oe_out),
    .sample_window_out(sample_window_out), .hold_out(hold_out), .powered_out(powered_out),
    .ref_hiz_out(ref_hiz_out), .trial_code_out(trial_code_out), .mux_route_out(mux_route_out));
  host_model host_model_inst (.clk_in(clk_in), .wire_in(wire_lv), .select_n_out(select_n),
    .sclk_out(sclk), .drive_out(hdrive), .oe_out(hoe));
  task automatic give_verdict();
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conv(input logic [2:0] cfg, input logic [11:0] v, input logic [4:0] rt);
    logic [35:0] e;
    e = '0;
    target = v;
    idx = 0;
    for (int k = 0; k < 12; k++) e[7+k] = v[11-k];
    for (int k = 1; k < 12; k++) e[18+k] = v[k] & ~cfg[0];
    host_model_inst.transfer(cfg, 36);
    chk({host_model_inst.rx[35:6], 6'h00}, e);
    chk(smp, 36'h000000030);
    chk(hld, 36'h00003ffc0);
    chk(pwr, 36'h00003ffff);
    chk(oe, 36'hfffffffc0);
    chk({31'h0, mux_route_out}, {31'h0, rt});
    chk({35'h0, ref_hiz_out}, 36'h1);
    chk({24'h0, trial_code_out}, {24'h0, v});
    host_model_inst.end_frame();
    chk({34'h0, data_oe_out, powered_out}, 36'h0);
  endtask
  task automatic abort_and_noise();
    host_model_inst.transfer(3'b101, 12);
    host_model_inst.end_frame();
    host_model_inst.noise();
    chk({31'h0, data_oe_out, powered_out, ref_hiz_out, hold_out, sample_window_out},
        36'h4);
  endtask
  initial begin
    repeat (4) @(negedge clk_in);
    rstn_in = 1'b1;
    conv(3'b100, 12'h000, 5'h0c);
    conv(3'b111, 12'hfff, 5'h14);
    conv(3'b001, 12'ha5c, 5'h0a);
    abort_and_noise();
    conv(3'b010, 12'h5a3, 5'h11);
    give_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    bad_count++;
    give_verdict();
  end
endmodule
